// ===== src/plrs_pkg.sv
package plrs_pkg;
  localparam logic [4:0] PLRS_REG_OFFSET = 5'h11;
  localparam int PLRS_MODE_MSB = 15;
  localparam int PLRS_MODE_LSB = 12;
  localparam int PLRS_ADDR_MSB = 8;
  localparam int PLRS_ADDR_LSB = 4;
  localparam int PLRS_MON_MSB = 3;
  localparam int PLRS_MON_LSB = 0;
  localparam logic [3:0] PLRS_MODE_RESET = 4'hf;
  localparam logic [3:0] PLRS_MON_RESET = 4'h0;
  localparam logic [4:0] PLRS_ADDR_RESET = 5'h01;

  typedef enum logic [3:0] {
    PLRS_ST_IDLE = 4'b0000,
    PLRS_ST_ABILITY_MATCH = 4'b0001,
    PLRS_ST_ACK_MATCH = 4'b0010,
    PLRS_ST_ACK_FAIL = 4'b0011,
    PLRS_ST_CONSIST_MATCH = 4'b0100,
    PLRS_ST_CONSIST_FAIL = 4'b0101,
    PLRS_ST_PD_READY = 4'b0110,
    PLRS_ST_PD_FAIL = 4'b0111,
    PLRS_ST_COMPLETE = 4'b1000
  } plrs_an_state_t;

  typedef struct packed {
    logic fast_full_duplex_flag;
    logic fast_half_duplex_flag;
    logic slow_full_duplex_flag;
    logic slow_half_duplex_flag;
  } plrs_mode_t;

  typedef struct packed {
    logic valid;
    plrs_mode_t mode;
    plrs_an_state_t state;
  } plrs_an_feed_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } plrs_mgmt_req_t;
endpackage : plrs_pkg

// ===== src/plrs_field.sv
`timescale 1ns/1ps
`default_nettype none
module plrs_field
  #(parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0)
  (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // load
  input wire logic load_i,
  input wire logic [WIDTH-1:0] data_i,
  // value
  output logic [WIDTH-1:0] value_o
  );
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      value_o <= RESET_VAL;
    end
    else if (load_i)
    begin
      value_o <= data_i;
    end
  end
endmodule : plrs_field
`default_nettype wire

// ===== src/plrs_status_reg.sv
`timescale 1ns/1ps
`default_nettype none
module plrs_status_reg
  import plrs_pkg::*;
  #(parameter logic [4:0] ADDR_RESET = PLRS_ADDR_RESET)
  (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // management register access
  input wire plrs_mgmt_req_t req_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  // auto-negotiation engine feed
  input wire plrs_an_feed_t an_i,
  // address to the serial management frame decoder
  output logic [4:0] mgmt_station_address_o
  );
  // access decode
  logic hit;
  logic wr_hit;
  logic rd_hit;

  // negotiated mode flags
  logic mode_load;
  logic fast_full_duplex_flag;
  logic fast_half_duplex_flag;
  logic slow_full_duplex_flag;
  logic slow_half_duplex_flag;
  plrs_mode_t mode_val;

  // state monitor
  logic mon_load;
  plrs_an_state_t mon_nxt;
  logic [3:0] mon_val;

  // address field and read word
  logic [4:0] addr_val;
  logic [15:0] word;

  // only one register index maps here
  assign hit = (req_i.addr == PLRS_REG_OFFSET);
  assign wr_hit = req_i.wr && hit;
  assign rd_hit = req_i.rd && hit;

  // latch on completion
  // result is held until the next completion, so a stale mode survives a link drop
  assign mode_load = an_i.valid && (an_i.state == PLRS_ST_COMPLETE);

  plrs_field #(.WIDTH(1), .RESET_VAL(PLRS_MODE_RESET[3])) u_fast_full (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(mode_load),
    .data_i(an_i.mode.fast_full_duplex_flag),
    .value_o(fast_full_duplex_flag)
  );

  plrs_field #(.WIDTH(1), .RESET_VAL(PLRS_MODE_RESET[2])) u_fast_half (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(mode_load),
    .data_i(an_i.mode.fast_half_duplex_flag),
    .value_o(fast_half_duplex_flag)
  );

  plrs_field #(.WIDTH(1), .RESET_VAL(PLRS_MODE_RESET[1])) u_slow_full (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(mode_load),
    .data_i(an_i.mode.slow_full_duplex_flag),
    .value_o(slow_full_duplex_flag)
  );

  plrs_field #(.WIDTH(1), .RESET_VAL(PLRS_MODE_RESET[0])) u_slow_half (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(mode_load),
    .data_i(an_i.mode.slow_half_duplex_flag),
    .value_o(slow_half_duplex_flag)
  );

  // flags gathered in register bit order
  assign mode_val = {
    fast_full_duplex_flag,
    fast_half_duplex_flag,
    slow_full_duplex_flag,
    slow_half_duplex_flag
  };

  // known codes pass through
  // an undefined code shows idle, so debug software never reads a code with no meaning
  always_comb
  begin
    mon_nxt = PLRS_ST_IDLE;
    unique case (an_i.state)
      PLRS_ST_IDLE: mon_nxt = PLRS_ST_IDLE;
      PLRS_ST_ABILITY_MATCH: mon_nxt = PLRS_ST_ABILITY_MATCH;
      PLRS_ST_ACK_MATCH: mon_nxt = PLRS_ST_ACK_MATCH;
      PLRS_ST_ACK_FAIL: mon_nxt = PLRS_ST_ACK_FAIL;
      PLRS_ST_CONSIST_MATCH: mon_nxt = PLRS_ST_CONSIST_MATCH;
      PLRS_ST_CONSIST_FAIL: mon_nxt = PLRS_ST_CONSIST_FAIL;
      PLRS_ST_PD_READY: mon_nxt = PLRS_ST_PD_READY;
      PLRS_ST_PD_FAIL: mon_nxt = PLRS_ST_PD_FAIL;
      PLRS_ST_COMPLETE: mon_nxt = PLRS_ST_COMPLETE;
      default: mon_nxt = PLRS_ST_IDLE;
    endcase
  end

  // monitor tracks state
  // loads every cycle, valid or not, so it shows the engine live
  assign mon_load = 1'b1;
  plrs_field #(.WIDTH(4), .RESET_VAL(PLRS_MON_RESET)) u_mon (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .load_i(mon_load),
    .data_i(mon_nxt),
    .value_o(mon_val)
  );

  for (genvar b = 0; b < 5; b++)
  begin : g_addr
    plrs_field #(.WIDTH(1), .RESET_VAL(ADDR_RESET[b])) u_bit (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .load_i(wr_hit),
      .data_i(req_i.wdata[PLRS_ADDR_LSB + b]),
      .value_o(addr_val[b])
    );
  end

  always_comb
  begin
    word = 16'h0000;
    word[PLRS_MODE_MSB:PLRS_MODE_LSB] = mode_val;
    word[PLRS_ADDR_MSB:PLRS_ADDR_LSB] = addr_val;
    word[PLRS_MON_MSB:PLRS_MON_LSB] = mon_val;
  end

  // read answer strobe, one cycle per read
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.rd;
    end
  end

  // read data holds until the next read; unmapped offsets read zero
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 16'h0000;
    end
    else if (rd_hit)
    begin
      rdata_o <= word;
    end
    else if (req_i.rd)
    begin
      rdata_o <= 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mgmt_station_address_o <= ADDR_RESET;
    end
    else
    begin
      mgmt_station_address_o <= addr_val;
    end
  end
endmodule : plrs_status_reg
`default_nettype wire

// ===== verif/plrs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module plrs_sva
  import plrs_pkg::*;
  (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire plrs_mgmt_req_t req_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire plrs_an_feed_t an_i,
  input wire logic [4:0] mgmt_station_address_o
  );
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire rd = req_i.rd && req_i.addr == 5'h11;
  wire wr = req_i.wr && req_i.addr == 5'h11;
  logic [3:0] m_r;
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) m_r <= 4'hf;
    else if (an_i.valid && an_i.state == PLRS_ST_COMPLETE) m_r <= an_i.mode;
  mode_a: assert property (rd |=> rdata_o[15:12] == $past(m_r)) else $error("mode");
  ans_a: assert property (req_i.rd |=> rvalid_o) else $error("ans");
  resv_a: assert property (rd |=> !rdata_o[11:9]) else $error("resv");
  mon_a: assert property (rd |=> rdata_o[3:0] == $past(an_i.state, 2)) else $error("mon");
  adr_rd_a: assert property (rd |=> rdata_o[8:4] == mgmt_station_address_o) else $error("adr");
  adr_wr_a: assert property (wr |-> ##2 mgmt_station_address_o == $past(req_i.wdata[8:4], 2)) else $error("wr");
  adr_keep_a: assert property (!wr |=> ##1 $stable(mgmt_station_address_o)) else $error("keep");
  unmap_a: assert property (req_i.rd && !rd |=> !rdata_o) else $error("unmap");
endmodule : plrs_sva
`default_nettype wire

// ===== verif/plrs_mgr.sv
`timescale 1ns/1ps
`default_nettype none
module plrs_mgr
  import plrs_pkg::*;
  (
  input wire logic clock_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output var plrs_mgmt_req_t req_o
  );
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [16:0] q);
    req_o <= '{w, !w, a, d};
    @(posedge clock_i);
    // released data flips so a stale value never matches
    req_o <= '{1'b0, 1'b0, a, ~d};
    // answer is registered on the taking edge; look mid-cycle after it
    @(negedge clock_i);
    q = {rvalid_i, rdata_i};
    @(posedge clock_i);
  endtask : xfer
endmodule : plrs_mgr
`default_nettype wire

// ===== verif/phy_link_result_status_reg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module phy_link_result_status_reg_tb_top;
  import plrs_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: bad %h", $time, g); end end
  logic clock_i = 0, resetn_i = 0, rvalid;
  logic [15:0] rdata;
  logic [16:0] q;
  logic [4:0] addr;
  plrs_mgmt_req_t req;
  plrs_an_feed_t an = '0;
  int mismatches = 0, compares = 0;
  plrs_status_reg dut (.clock_i, .resetn_i, .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .an_i(an),
    .mgmt_station_address_o(addr));
  plrs_mgr mgr (.clock_i, .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial forever #5 clock_i = ~clock_i;
  initial
  begin
    #20000 mismatches++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    mgr.xfer(0, 5'h11, 16'h0, q);
    `CHK(q, 17'h1f010)
    mgr.xfer(1, 5'h11, 16'hffff, q);
    mgr.xfer(1, 5'h10, 16'h0, q);
    mgr.xfer(0, 5'h10, 16'h0, q);
    `CHK({q, addr}, {17'h10000, 5'h1f})
    $display("register test done");
    for (int i = 0; i < 12; i++)
    begin
      an <= '{i < 11, plrs_mode_t'(4'h1 << i % 4), plrs_an_state_t'(i < 8 ? i : 8)};
      @(posedge clock_i);
      mgr.xfer(0, 5'h11, 16'h0, q);
      `CHK(q, {1'b1, i < 8 ? 4'hf : 4'h1 << (i > 10 ? 2 : i % 4), 8'h1f, i < 8 ? i[3:0] : 4'h8})
    end
    $display("negotiation test done");
    give_verdict();
  end
endmodule : phy_link_result_status_reg_tb_top
bind plrs_status_reg plrs_sva sva (.clock_i, .resetn_i, .req_i, .rdata_o, .rvalid_o, .an_i, .mgmt_station_address_o);
`default_nettype wire
